// File: verilog/flash_boot_params.svh
// Constants for the serial boot command interpreter
`ifndef FLASH_BOOT_PARAMS_SVH
`define FLASH_BOOT_PARAMS_SVH
`define FSB_CMD_PAGE_READ 8'hFF
`define FSB_CMD_PAGE_PROG 8'h41
`define FSB_CMD_BLK_ERASE 8'h20
`define FSB_CMD_ERASE_ALL 8'hA7
`define FSB_CMD_READ_STAT 8'h70
`define FSB_CMD_CLR_STAT 8'h50
`define FSB_CMD_READ_LOCK 8'h71
`define FSB_CMD_LOCK_PROG 8'h77
`define FSB_CMD_ID_CHECK 8'hF5
`define FSB_CMD_VERSION 8'hFB
`define FSB_CMD_BOOT_READ 8'hFC
`define FSB_CMD_CHECK_DATA 8'hFD
`define FSB_CONFIRM 8'hD0
`define FSB_PAGE_LAST 9'h0FF
`define FSB_VERSION_LAST 9'h007
`define FSB_TAIL_PAGE 9'h102
`define FSB_TAIL_ADDR_CONF 9'h003
`define FSB_TAIL_ONE 9'h001
`define FSB_TAIL_TWO 9'h002
`define FSB_TAIL_ID 9'h00B
`define FSB_TAIL_VERSION 9'h008
`define FSB_SR_READY 7
`define FSB_SR_ERASE_ERR 5
`define FSB_SR_PROG_ERR 4
`define FSB_SR_REJECT 3
`define FSB_SR1_ID_OK 2
`define FSB_SR1_BLANK 1
`define FSB_BITS_PER_UNIT 3'h7
`define FSB_SETTLE_DONE 2'h3
`endif

// File: verilog/flash_boot_pkg.sv
// Types for the serial boot command interpreter
`default_nettype none
package flash_boot_pkg;
  typedef enum logic [2:0] {
    op_read,
    op_program,
    op_erase_block,
    op_erase_all,
    op_read_lock,
    op_lock_program,
    op_boot_read
  } flash_op_e;

  typedef struct packed {
    logic valid;
    flash_op_e op;
    logic [23:0] addr;
    logic [7:0] wdata;
  } flash_req_s;

  typedef enum logic [3:0] {
    st_cmd,
    st_addr_mid,
    st_addr_hi,
    st_confirm,
    st_rx_data,
    st_wait,
    st_fetch,
    st_tx,
    st_discard
  } boot_state_e;
endpackage
`default_nettype wire

// File: verilog/boot_serial_link.sv
// Link-side shifter running on the transfer clock
`timescale 1ns/1ns
`default_nettype none
`include "flash_boot_params.svh"
module boot_serial_link (
  input wire logic link_clk_in,
  input wire logic rst_in,
  input wire logic rx_line_in,
  input wire logic [7:0] tx_data_in,
  output logic [7:0] rx_byte_out,
  output logic rx_toggle_out,
  output logic active_out,
  output logic tx_line_out
);
  // ----------------------------------------
  // Bit counting and shifting
  // ----------------------------------------
  logic [2:0] bit_idx;
  logic [6:0] shift;
  wire last_bit = (bit_idx == `FSB_BITS_PER_UNIT);

  // Sample on rise, LSB arrives first
  always_ff @(posedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bit_idx <= 3'h0;
      shift <= 7'h00;
      rx_byte_out <= 8'h00;
      rx_toggle_out <= 1'b0;
      active_out <= 1'b0;
    end
    else
    begin
      bit_idx <= bit_idx + 3'h1;
      shift <= {rx_line_in, shift[6:1]};
      active_out <= ~last_bit;
      if (last_bit)
      begin
        rx_byte_out <= {rx_line_in, shift};
        rx_toggle_out <= ~rx_toggle_out;
      end
    end
  end

  // Clock idles high, so each bit opens with a fall
  // Core word is held still while busy is low, so no sync here
  always_ff @(negedge link_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_line_out <= 1'b1;
    end
    else
    begin
      tx_line_out <= tx_data_in[bit_idx];
    end
  end
endmodule
`default_nettype wire

// File: verilog/flash_serial_boot_sync_cmd.sv
// Clock-synchronised serial boot command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "flash_boot_params.svh"
// Functional notes
// - Clock pin high at reset selects mode
// - Receive bits sampled on transfer clock rise
// - Transmit bits driven on transfer clock fall
// - Eight-bit units, least significant bit first
// - Busy high while working, low when ready
// - Page read returns one 256-byte page
// - Bytes two and three carry page address
// - Page bytes from fourth byte, ascending
// - A7 then D0 erases unlocked blocks
// - 71 plus address returns lock byte
// - FB returns version bytes to ninth
// - FC plus address returns boot data
// - Blank flash accepts every command
// - 70 returns both status bytes, ungated
// - Status shows state and last result
// - 41, address, 256 bytes programs page
// - 20, address, D0 erases one block
// - Gated commands need verified ID code
// - 50 clears error bits, then ready
module flash_serial_boot_sync_cmd #(
  parameter logic [63:0] VERSION_DATA = 64'h0706050403020100 // Arbitrary
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic transfer_clock_pin_in,
  input wire logic serial_receive_line_in,
  output logic serial_transmit_line_out,
  output logic busy_indicator_pin_out,
  output logic sync_mode_out,
  output flash_boot_pkg::flash_req_s flash_req_out,
  input wire logic flash_done_in,
  input wire logic flash_fail_in,
  input wire logic [7:0] flash_rdata_in,
  input wire logic flash_blank_in,
  input wire logic id_verified_in
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Bytes still to come after a first byte that is not served
  function automatic logic [8:0] tail_len(input logic [7:0] c);
    if (c == `FSB_CMD_PAGE_READ || c == `FSB_CMD_BOOT_READ ||
        c == `FSB_CMD_PAGE_PROG)
      tail_len = `FSB_TAIL_PAGE;
    else if (c == `FSB_CMD_BLK_ERASE || c == `FSB_CMD_LOCK_PROG ||
             c == `FSB_CMD_READ_LOCK)
      tail_len = `FSB_TAIL_ADDR_CONF;
    else if (c == `FSB_CMD_ERASE_ALL)
      tail_len = `FSB_TAIL_ONE;
    else if (c == `FSB_CMD_CHECK_DATA || c == `FSB_CMD_READ_STAT)
      tail_len = `FSB_TAIL_TWO;
    else if (c == `FSB_CMD_ID_CHECK)
      tail_len = `FSB_TAIL_ID;
    else if (c == `FSB_CMD_VERSION)
      tail_len = `FSB_TAIL_VERSION;
    else
      tail_len = 9'h000;
  endfunction

  function automatic logic [7:0] version_byte(input logic [8:0] i);
    version_byte = VERSION_DATA[{i[2:0], 3'h0} +: 8];
  endfunction

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  logic [7:0] tx_data;
  logic [7:0] link_byte;
  logic link_toggle;
  logic link_active;

  boot_serial_link u_link (
    .link_clk_in(transfer_clock_pin_in),
    .rst_in(rst_in),
    .rx_line_in(serial_receive_line_in),
    .tx_data_in(tx_data),
    .rx_byte_out(link_byte),
    .rx_toggle_out(link_toggle),
    .active_out(link_active),
    .tx_line_out(serial_transmit_line_out)
  );

  // ----------------------------------------
  // Crossings and mode capture
  // ----------------------------------------
  logic mode_s1, mode_s2;
  logic tog_s1, tog_s2, tog_s3;
  logic act_s1, act_s2;
  logic [1:0] settle;
  logic mode_taken;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mode_s1 <= 1'b0;
      mode_s2 <= 1'b0;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end
    else
    begin
      mode_s1 <= transfer_clock_pin_in;
      mode_s2 <= mode_s1;
      tog_s1 <= link_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      act_s1 <= link_active;
      act_s2 <= act_s1;
    end
  end

  // Pin level is caught once the synchroniser has settled after release
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      settle <= 2'h0;
      mode_taken <= 1'b0;
      sync_mode_out <= 1'b0;
    end
    else if (!mode_taken)
    begin
      settle <= settle + 2'h1;
      if (settle == `FSB_SETTLE_DONE)
      begin
        mode_taken <= 1'b1;
        sync_mode_out <= mode_s2;
      end
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  flash_boot_pkg::boot_state_e state, next_state;
  logic [7:0] cmd, next_cmd;
  logic [7:0] addr_mid, next_addr_mid;
  logic [7:0] addr_hi, next_addr_hi;
  logic [8:0] count, next_count;
  logic [8:0] tail, next_tail;
  logic [7:0] next_tx;
  logic [5:3] errs, next_errs;
  flash_boot_pkg::flash_req_s next_req;
  logic next_busy;

  // Byte is stable: host may not clock again until busy falls
  wire rx_event = sync_mode_out & (tog_s2 ^ tog_s3);
  wire [7:0] rx = link_byte;
  wire ungated = (rx == `FSB_CMD_READ_STAT) ||
                 (rx == `FSB_CMD_VERSION) ||
                 (rx == `FSB_CMD_ID_CHECK);
  wire allowed = id_verified_in | flash_blank_in | ungated;
  wire served = (rx == `FSB_CMD_PAGE_READ) || (rx == `FSB_CMD_BOOT_READ) ||
                (rx == `FSB_CMD_PAGE_PROG) || (rx == `FSB_CMD_BLK_ERASE) ||
                (rx == `FSB_CMD_LOCK_PROG) || (rx == `FSB_CMD_READ_LOCK) ||
                (rx == `FSB_CMD_ERASE_ALL) || (rx == `FSB_CMD_READ_STAT) ||
                (rx == `FSB_CMD_CLR_STAT) || (rx == `FSB_CMD_VERSION);
  wire is_read = (cmd == `FSB_CMD_PAGE_READ) || (cmd == `FSB_CMD_BOOT_READ);
  wire flash_idle = (state != flash_boot_pkg::st_wait) &&
                    (state != flash_boot_pkg::st_fetch);
  wire [7:0] status_main = {flash_idle, 1'b0, errs, 3'h0};
  wire [7:0] status_aux = {5'h00, id_verified_in, flash_blank_in, 1'b0};
  wire [23:0] page_addr = {addr_hi, addr_mid, count[7:0]};
  wire flash_op_err = flash_done_in & flash_fail_in;
  wire prog_op = (flash_req_out.op == flash_boot_pkg::op_program) ||
                 (flash_req_out.op == flash_boot_pkg::op_lock_program);

  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_addr_mid = addr_mid;
    next_addr_hi = addr_hi;
    next_count = count;
    next_tail = tail;
    next_tx = tx_data;
    next_errs = errs;
    next_req = flash_req_out;
    next_req.valid = 1'b0;
    case (state)
      flash_boot_pkg::st_cmd:
        if (rx_event)
        begin
          next_cmd = rx;
          next_count = 9'h000;
          if (!(allowed && served))
          begin
            // Flash is left alone, remaining bytes are swallowed
            next_tail = tail_len(rx);
            next_errs[`FSB_SR_REJECT] = errs[`FSB_SR_REJECT] | ~allowed;
            if (tail_len(rx) != 9'h000)
              next_state = flash_boot_pkg::st_discard;
          end
          else if (rx == `FSB_CMD_ERASE_ALL)
            next_state = flash_boot_pkg::st_confirm;
          else if (rx == `FSB_CMD_READ_STAT)
          begin
            next_tx = status_main;
            next_state = flash_boot_pkg::st_tx;
          end
          else if (rx == `FSB_CMD_CLR_STAT)
            next_errs = 3'h0;
          else if (rx == `FSB_CMD_VERSION)
          begin
            next_tx = version_byte(9'h000);
            next_state = flash_boot_pkg::st_tx;
          end
          else
            next_state = flash_boot_pkg::st_addr_mid;
        end
      flash_boot_pkg::st_addr_mid:
        if (rx_event)
        begin
          next_addr_mid = rx;
          next_state = flash_boot_pkg::st_addr_hi;
        end
      flash_boot_pkg::st_addr_hi:
        if (rx_event)
        begin
          next_addr_hi = rx;
          next_req.addr = {rx, addr_mid, 8'h00};
          if (is_read || cmd == `FSB_CMD_READ_LOCK)
          begin
            next_req.valid = 1'b1;
            next_req.op = (cmd == `FSB_CMD_PAGE_READ) ?
                          flash_boot_pkg::op_read :
                          (cmd == `FSB_CMD_BOOT_READ) ?
                          flash_boot_pkg::op_boot_read :
                          flash_boot_pkg::op_read_lock;
            next_state = flash_boot_pkg::st_fetch;
          end
          else if (cmd == `FSB_CMD_PAGE_PROG)
            next_state = flash_boot_pkg::st_rx_data;
          else
            next_state = flash_boot_pkg::st_confirm;
        end
      flash_boot_pkg::st_confirm:
        if (rx_event)
        begin
          next_state = flash_boot_pkg::st_cmd;
          if (rx == `FSB_CONFIRM)
          begin
            next_req.valid = 1'b1;
            next_req.op = (cmd == `FSB_CMD_ERASE_ALL) ?
                          flash_boot_pkg::op_erase_all :
                          (cmd == `FSB_CMD_LOCK_PROG) ?
                          flash_boot_pkg::op_lock_program :
                          flash_boot_pkg::op_erase_block;
            next_state = flash_boot_pkg::st_wait;
          end
          else
            next_errs[`FSB_SR_ERASE_ERR] = 1'b1;
        end
      flash_boot_pkg::st_rx_data:
        if (rx_event)
        begin
          next_req.valid = 1'b1;
          next_req.op = flash_boot_pkg::op_program;
          next_req.addr = page_addr;
          next_req.wdata = rx;
          next_state = flash_boot_pkg::st_wait;
        end
      flash_boot_pkg::st_wait:
        if (flash_done_in)
        begin
          if (flash_op_err)
          begin
            if (prog_op)
              next_errs[`FSB_SR_PROG_ERR] = 1'b1;
            else
              next_errs[`FSB_SR_ERASE_ERR] = 1'b1;
          end
          if (cmd == `FSB_CMD_PAGE_PROG && count != `FSB_PAGE_LAST)
          begin
            next_count = count + 9'h001;
            next_state = flash_boot_pkg::st_rx_data;
          end
          else
            next_state = flash_boot_pkg::st_cmd;
        end
      flash_boot_pkg::st_fetch:
        if (flash_done_in)
        begin
          next_tx = flash_rdata_in;
          next_state = flash_boot_pkg::st_tx;
        end
      flash_boot_pkg::st_tx:
        if (rx_event)
        begin
          next_count = count + 9'h001;
          next_state = flash_boot_pkg::st_cmd;
          if (cmd == `FSB_CMD_READ_STAT && count == 9'h000)
          begin
            next_tx = status_aux;
            next_state = flash_boot_pkg::st_tx;
          end
          else if (cmd == `FSB_CMD_VERSION && count != `FSB_VERSION_LAST)
          begin
            next_tx = version_byte(count + 9'h001);
            next_state = flash_boot_pkg::st_tx;
          end
          else if (is_read && count != `FSB_PAGE_LAST)
          begin
            next_req.valid = 1'b1;
            next_req.addr = page_addr + 24'h000001;
            next_state = flash_boot_pkg::st_fetch;
          end
        end
      flash_boot_pkg::st_discard:
        if (rx_event)
        begin
          next_tail = tail - 9'h001;
          if (tail == 9'h001)
            next_state = flash_boot_pkg::st_cmd;
        end
      default:
        next_state = flash_boot_pkg::st_cmd;
    endcase
    // Low only when parked waiting on the host
    // Clock pin low means a byte has begun, ahead of link_active
    next_busy = ~sync_mode_out | act_s2 | ~mode_s2 |
                (next_state == flash_boot_pkg::st_wait) |
                (next_state == flash_boot_pkg::st_fetch);
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= flash_boot_pkg::st_cmd;
      cmd <= 8'h00;
      addr_mid <= 8'h00;
      addr_hi <= 8'h00;
      count <= 9'h000;
      tail <= 9'h000;
      tx_data <= 8'hFF;
      errs <= 3'h0;
      flash_req_out <= '0;
      busy_indicator_pin_out <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      addr_mid <= next_addr_mid;
      addr_hi <= next_addr_hi;
      count <= next_count;
      tail <= next_tail;
      tx_data <= next_tx;
      errs <= next_errs;
      flash_req_out <= next_req;
      busy_indicator_pin_out <= next_busy;
    end
  end
endmodule
`default_nettype wire

// File: tb/flash_boot_asserts.sv
// Port-level checks for the serial boot interpreter
`timescale 1ns/1ns
`default_nettype none
module flash_boot_asserts (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic transfer_clock_pin_in,
  input wire logic serial_transmit_line_out,
  input wire logic busy_indicator_pin_out,
  input wire logic sync_mode_out,
  input wire flash_boot_pkg::flash_req_s flash_req_out,
  input wire logic flash_done_in
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // ------------------------------------------------------------
  // Mode strap
  // ------------------------------------------------------------
  property p_no_mode_busy;
    !sync_mode_out |-> busy_indicator_pin_out;
  endproperty
  a_no_mode_busy: assert property (p_no_mode_busy)
    else $error("busy low outside sync mode");
  property p_mode_strap;
    $rose(sync_mode_out) |-> $past(transfer_clock_pin_in, 3);
  endproperty
  a_mode_strap: assert property (p_mode_strap)
    else $error("sync mode with clock pin low");
  property p_mode_hold;
    sync_mode_out |=> sync_mode_out;
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("sync mode dropped");
  // ------------------------------------------------------------
  // Link and busy
  // ------------------------------------------------------------
  property p_mode_ready;
    $rose(sync_mode_out) |-> ##[1:2] !busy_indicator_pin_out;
  endproperty
  a_mode_ready: assert property (p_mode_ready)
    else $error("busy stuck after mode entry");
  // Tx may only move while the transfer clock is low
  property p_tx_on_fall;
    $changed(serial_transmit_line_out) |-> !transfer_clock_pin_in;
  endproperty
  a_tx_on_fall: assert property (p_tx_on_fall)
    else $error("tx changed with clock high");
  property p_busy_frame;
    (!transfer_clock_pin_in) [*5] |-> busy_indicator_pin_out;
  endproperty
  a_busy_frame: assert property (p_busy_frame)
    else $error("busy low inside a byte");
  // ------------------------------------------------------------
  // Flash port
  // ------------------------------------------------------------
  property p_req_single;
    flash_req_out.valid |=> (!flash_req_out.valid) [*8];
  endproperty
  a_req_single: assert property (p_req_single)
    else $error("flash request repeated");
  property p_busy_op;
    flash_req_out.valid |->
      busy_indicator_pin_out throughout (##[1:20] flash_done_in);
  endproperty
  a_busy_op: assert property (p_busy_op)
    else $error("busy low during flash op");
  property p_done_ready;
    flash_done_in |-> ##[1:8] !busy_indicator_pin_out;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("busy stuck after flash op");
endmodule
`default_nettype wire

// File: tb/boot_programmer.sv
// Behavioural serial programmer on the boot link
`timescale 1ns/1ns
`default_nettype none
module boot_programmer (
  input wire logic clock_in,
  input wire logic busy_in,
  input wire logic tx_line_in,
  output logic sclk_out,
  output logic rx_line_out
);
  // Idle clock high doubles as the mode strap
  initial
  begin
    sclk_out = 1'b1;
    rx_line_out = 1'b1;
  end
  // Pin level across a reset release picks the mode
  task automatic strap(input logic lvl);
    #1;
    sclk_out = lvl;
  endtask
  // One byte each way; gap makes the host slow
  task automatic xfer(input logic [7:0] d, input int gap,
                      output logic [7:0] r);
    int n;
    n = 0;
    repeat (4) @(posedge clock_in);
    while (busy_in !== 1'b0 && n < 20000)
    begin
      @(posedge clock_in);
      n++;
    end
    repeat (4 + gap) @(posedge clock_in);
    #1;
    for (int i = 0; i < 8; i++)
    begin
      sclk_out = 1'b0;
      rx_line_out = d[i];
      #62;
      sclk_out = 1'b1;
      r[i] = tx_line_in;
      #63;
    end
    // Released line must not keep the last bit
    rx_line_out = ~d[7];
  endtask
endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the serial boot interpreter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam logic [63:0] VER = 64'h8877665544332211; // Arbitrary
  localparam logic [7:0] LOCK = 8'h3C;
  localparam logic [7:0] ECODE[3] = '{8'h20, 8'h77, 8'hA7};
  localparam logic [2:0] EOP[3] = '{3'h2, 3'h5, 3'h3};
  localparam logic [7:0] EST[3] = '{8'hA0, 8'h90, 8'hA0};
  logic clock_in;
  logic rst_in = 1'b1;
  logic sclk;
  logic rxd;
  logic txd;
  logic busy;
  logic sync_mode;
  flash_boot_pkg::flash_req_s req;
  flash_boot_pkg::flash_req_s pend;
  logic done = 1'b0;
  logic fail = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic blank = 1'b0;
  logic id_ok = 1'b0;
  logic fail_next = 1'b0;
  int dly = 0;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] q[$];
  logic [7:0] rx_q[$];
  flash_boot_pkg::flash_req_s req_q[$];
  logic [7:0] mid;
  logic [7:0] hi;
  flash_serial_boot_sync_cmd #(.VERSION_DATA(VER)) u_dut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .transfer_clock_pin_in(sclk),
    .serial_receive_line_in(rxd),
    .serial_transmit_line_out(txd),
    .busy_indicator_pin_out(busy),
    .sync_mode_out(sync_mode),
    .flash_req_out(req),
    .flash_done_in(done),
    .flash_fail_in(fail),
    .flash_rdata_in(rdata),
    .flash_blank_in(blank),
    .id_verified_in(id_ok)
  );
  boot_programmer u_host (
    .clock_in(clock_in),
    .busy_in(busy),
    .tx_line_in(txd),
    .sclk_out(sclk),
    .rx_line_out(rxd)
  );
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // ------------------------------------------------------------
  // Flash array model, random answer delay
  // ------------------------------------------------------------
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] rnd();
    return 8'($urandom);
  endfunction
  always @(posedge clock_in)
  begin
    done <= 1'b0;
    if (dly == 1)
    begin
      done <= 1'b1;
      fail <= fail_next;
      rdata <= (pend.op == flash_boot_pkg::op_read_lock) ? LOCK
               : mem(pend.addr);
    end
    if (dly > 0)
      dly <= dly - 1;
    if (req.valid === 1'b1)
    begin
      req_q.push_back(req);
      pend <= req;
      dly <= 3 + int'($urandom_range(4));
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_req(input int i, input logic [23:0] a);
    check(24'(req_q[i].addr), a);
  endtask
  task automatic send();
    logic [7:0] r;
    int n;
    rx_q.delete();
    req_q.delete();
    foreach (q[i])
    begin
      u_host.xfer(q[i], int'($urandom_range(3)), r);
      rx_q.push_back(r);
    end
    n = 0;
    repeat (8) @(posedge clock_in);
    while (busy !== 1'b0 && n < 2000)
    begin
      @(posedge clock_in);
      n++;
    end
  endtask
  task automatic status(input logic [7:0] p, input logic [7:0] s);
    q = '{8'h70, rnd(), rnd()};
    send();
    check(24'(rx_q[1]), 24'(p));
    check(24'(rx_q[2]), 24'(s));
  endtask
  task automatic gate(input logic b, input logic i);
    @(posedge clock_in);
    blank <= b;
    id_ok <= i;
  endtask
  task automatic stop_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Whole run is near 80k cycles; this bounds a hang
  initial
  begin
    #800000;
    fail_count++;
    stop_test();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(51));
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    check(24'(sync_mode), 24'h1);
    check(24'(busy), 24'h0);
    status(8'h80, 8'h00);
    mid = rnd();
    hi = rnd();
    q = '{8'h20, mid, hi, 8'hD0};
    send();
    check(24'(req_q.size()), 24'h0);
    status(8'h88, 8'h00);
    gate(1'b0, 1'b1);
    q = '{8'h50};
    send();
    status(8'h80, 8'h04);
    gate(1'b1, 1'b0);
    q = '{8'hFF, mid, hi};
    repeat (256) q.push_back(rnd());
    send();
    check(24'(req_q.size()), 24'h100);
    for (int i = 0; i < 256; i++)
    begin
      check(24'(rx_q[3 + i]), 24'(mem({hi, mid, 8'(i)})));
      check_req(i, {hi, mid, 8'(i)});
    end
    gate(1'b0, 1'b1);
    q = '{8'h41, mid, hi};
    repeat (256) q.push_back(rnd());
    send();
    for (int i = 0; i < 256; i++)
    begin
      check(24'(req_q[i].op), 24'h1);
      check_req(i, {hi, mid, 8'(i)});
      check(24'(req_q[i].wdata), 24'(q[3 + i]));
    end
    // Each erase or lock answers with a flash failure
    for (int k = 0; k < 3; k++)
    begin
      fail_next = 1'b1;
      q = '{ECODE[k], 8'hD0};
      if (k < 2)
        q = '{ECODE[k], mid, hi, 8'hD0};
      send();
      fail_next = 1'b0;
      check(24'(req_q.size()), 24'h1);
      check(24'(req_q[0].op), 24'(EOP[k]));
      if (k < 2)
        check(24'(req_q[0].addr[23:8]), 24'({hi, mid}));
      status(EST[k], 8'h04);
      q = '{8'h50};
      send();
    end
    q = '{8'hA7, 8'h55};
    send();
    check(24'(req_q.size()), 24'h0);
    status(8'hA0, 8'h04);
    q = '{8'h71, mid, hi, rnd()};
    send();
    check(24'(rx_q[3]), 24'(LOCK));
    check(24'(req_q[0].op), 24'h4);
    gate(1'b0, 1'b0);
    // Ungated ID payload is swallowed and flags no reject
    q = '{8'hF5};
    repeat (11) q.push_back(rnd());
    send();
    check(24'(req_q.size()), 24'h0);
    status(8'hA0, 8'h00);
    // Strap low across a mid-run reset leaves the link unused
    rst_in <= 1'b1;
    @(posedge clock_in);
    u_host.strap(1'b0);
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    check(24'(sync_mode), 24'h0);
    check(24'(busy), 24'h1);
    rst_in <= 1'b1;
    @(posedge clock_in);
    u_host.strap(1'b1);
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (12) @(posedge clock_in);
    check(24'(sync_mode), 24'h1);
    status(8'h80, 8'h00);
    q = '{8'hFB};
    repeat (8) q.push_back(rnd());
    send();
    for (int i = 0; i < 8; i++)
      check(24'(rx_q[1 + i]), 24'(VER[8 * i +: 8]));
    stop_test();
  end
endmodule
bind flash_serial_boot_sync_cmd flash_boot_asserts u_chk (
  .clock_in,
  .rst_in,
  .transfer_clock_pin_in,
  .serial_transmit_line_out,
  .busy_indicator_pin_out,
  .sync_mode_out,
  .flash_req_out,
  .flash_done_in
);
`default_nettype wire
